// ==== bnp_counter.sv ====
module bnp_counter
   import bnp_pkg::*;
(
   input wire logic sys_clk,             // System clock.
   input wire logic rst_n,               // Synchronous reset, active low.
   input wire logic clear,               // Restarts the count at zero.
   output logic [CNT_W-1:0] count        // Cycles since the last clear.
);

   logic [CNT_W-1:0] count_nxt;

   // Next count saturates so a long idle period cannot wrap it.
   always_comb begin
      if (clear) begin
         count_nxt = '0;
      end else if (count == {CNT_W{1'b1}}) begin
         count_nxt = count;
      end else begin
         count_nxt = count + 1'b1;
      end
   end

   // Registers the count.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= '0;
      end else begin
         count <= count_nxt;
      end
   end

endmodule : bnp_counter

// ==== bnp_host_ctrl.sv ====
module bnp_host_ctrl
   import bnp_pkg::*;
(
   input wire logic sys_clk,                        // System clock, 200 MHz.
   input wire logic rst_n,                          // Synchronous reset, active low.
   input wire logic req_valid,                      // Request present.
   input wire logic req_write,                      // High for write, low for read.
   input wire logic [ADDR_W-1:0] req_addr,          // Byte address of the request.
   input wire logic [DATA_W-1:0] req_wdata,         // Write data of the request.
   output logic req_ready,                          // Request taken this cycle.
   output logic rsp_valid,                          // Access finished, one-cycle pulse.
   output logic [DATA_W-1:0] rsp_rdata,             // Read data, held until next read.
   output logic [ADDR_W-1:0] mem_addr_lines,        // Address pins.
   output logic select_n,                           // Chip select, active low.
   output logic write_strobe_n,                     // Write strobe, active low.
   output logic output_drive_n,                     // Output enable, active low.
   input wire logic [DATA_W-1:0] byte_lanes_i,      // Data pins as seen on the wire.
   output logic [DATA_W-1:0] byte_lanes_o,          // Data driven by the host.
   output logic byte_lanes_oe_n                     // Host drives data while low.
);

   // ****************************************************************
   // Elaboration checks on the timing counts.
   // ****************************************************************
   // The access phase must leave room for precharge inside one cycle,
   // and the full cycle count must fit the saturating timer.
   if (ACCESS_CYC >= CYCLE_CYC || PRECHARGE_CYC > CYCLE_CYC - ACCESS_CYC ||
       CYCLE_CYC + 2 > (1 << CNT_W) - 1) begin : g_bad_timing
      $error("Timing counts do not fit the controller.");
   end

   // ****************************************************************
   // Input synchroniser for the data pins.
   // ****************************************************************
   logic [DATA_W-1:0] sync1_r;
   logic [DATA_W-1:0] sync2_r;

   // Two flip-flops before any logic reads the data pins.
   // The pins change at any time against sys_clk, so the first stage may
   // settle late; only the second stage feeds the sequencer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= byte_lanes_i;
         sync2_r <= sync1_r;
      end
   end

   // ****************************************************************
   // Cycle timer.
   // ****************************************************************
   // Cleared at every select fall; after reset it starts from zero, so the
   // first cycle after reset also waits out a full precharge.
   logic [CNT_W-1:0] tcount;
   logic tclear;

   bnp_counter u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(tclear),
      .count(tcount)
   );

   // ****************************************************************
   // Access sequencer.
   // ****************************************************************
   bnp_state_t state_r, state_nxt;
   logic is_write_r, is_write_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wdata_r, wdata_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic req_ready_r, req_ready_nxt;
   logic rsp_valid_r, rsp_valid_nxt;
   logic sel_r, sel_nxt;
   logic we_r, we_nxt;
   logic oe_r, oe_nxt;
   logic lanes_oe_r, lanes_oe_nxt;
   logic access_met;
   logic cycle_met;

   // Returns true once count has reached the given number of cycles.
   function automatic logic reached(input logic [CNT_W-1:0] cnt, input int limit);
      reached = (int'(cnt) >= limit - 1);
   endfunction : reached

   // The access phase ends once the access time and the two synchroniser
   // stages have passed, so the read data taken then is already valid.
   assign access_met = reached(tcount, ACCESS_CYC + 2);

   // The timer saturates, so a long idle period keeps cycle_met high.
   // Gating requests on it also covers an access cut short by reset,
   // which the array still completes internally before its precharge.
   assign cycle_met = reached(tcount, CYCLE_CYC + 2);

   // Next state: select falls with address stable, the access runs
   // for the full access time, then select rises for precharge.
   // A new request waits until the timer shows that select has stood
   // high long enough since the last cycle or since reset.
   always_comb begin
      state_nxt = state_r;
      is_write_nxt = is_write_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      req_ready_nxt = 1'b0;
      rsp_valid_nxt = 1'b0;
      sel_nxt = sel_r;
      we_nxt = we_r;
      oe_nxt = oe_r;
      lanes_oe_nxt = lanes_oe_r;
      tclear = 1'b0;
      case (state_r)
         BNP_IDLE: begin
            // Take the next request only once precharge and cycle time are met.
            if (req_valid && !req_ready_r && cycle_met) begin
               req_ready_nxt = 1'b1;
               is_write_nxt = req_write;
               addr_nxt = req_addr;
               wdata_nxt = req_wdata;
               sel_nxt = 1'b0;
               // Strobe low with select: select-controlled write.
               we_nxt = ~req_write;
               oe_nxt = req_write;
               lanes_oe_nxt = ~req_write;
               tclear = 1'b1;
               state_nxt = BNP_ACCESS;
            end
         end
         BNP_ACCESS: begin
            // Hold the access until the access time has passed.
            if (access_met) begin
               if (!is_write_r) begin
                  rdata_nxt = sync2_r;
               end
               // Select and strobe rise together to end the write.
               sel_nxt = 1'b1;
               we_nxt = 1'b1;
               oe_nxt = 1'b1;
               lanes_oe_nxt = 1'b1;
               state_nxt = BNP_PRECHARGE;
            end
         end
         BNP_PRECHARGE: begin
            // Select held high for precharge and until the cycle time.
            if (cycle_met) begin
               rsp_valid_nxt = 1'b1;
               state_nxt = BNP_DONE;
            end
         end
         BNP_DONE: begin
            // One quiet cycle separates the rsp_valid pulse from the next take.
            state_nxt = BNP_IDLE;
         end
         default: begin
            // An illegal state parks the pins idle and returns to IDLE.
            state_nxt = BNP_IDLE;
            sel_nxt = PIN_IDLE;
            we_nxt = PIN_IDLE;
            oe_nxt = PIN_IDLE;
            lanes_oe_nxt = 1'b1;
         end
      endcase
   end

   // Registers the sequencer; reset parks all strobes high.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r <= BNP_IDLE;
         is_write_r <= 1'b0;
         addr_r <= '0;
         wdata_r <= '0;
         rdata_r <= '0;
         req_ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         sel_r <= PIN_IDLE;
         we_r <= PIN_IDLE;
         oe_r <= PIN_IDLE;
         lanes_oe_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         is_write_r <= is_write_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         req_ready_r <= req_ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         sel_r <= sel_nxt;
         we_r <= we_nxt;
         oe_r <= oe_nxt;
         lanes_oe_r <= lanes_oe_nxt;
      end
   end

   // ****************************************************************
   // Pin and handshake outputs.
   // ****************************************************************
   // Outputs come straight from flip-flops.
   assign req_ready = req_ready_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp_rdata = rdata_r;
   assign mem_addr_lines = addr_r;
   assign select_n = sel_r;
   assign write_strobe_n = we_r;
   assign output_drive_n = oe_r;
   assign byte_lanes_o = wdata_r;
   assign byte_lanes_oe_n = lanes_oe_r;

endmodule : bnp_host_ctrl

// ==== bnp_host_ctrl_properties.sv ====
module bnp_host_ctrl_properties
   import bnp_pkg::*;
(
   input wire logic sys_clk, // Clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic req_ready, // Taken pulse.
   input wire logic rsp_valid, // Done pulse.
   input wire logic [ADDR_W-1:0] mem_addr_lines, // Address pins.
   input wire logic select_n, // Chip select.
   input wire logic write_strobe_n, // Write strobe.
   input wire logic output_drive_n, // Output enable.
   input wire logic [DATA_W-1:0] byte_lanes_o, // Host data.
   input wire logic byte_lanes_oe_n // Host drives while low.
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // Pin protocol checks.
   // ********
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_idle; $rose(rst_n) |-> select_n && write_strobe_n && output_drive_n; endproperty
   a_idle: assert property (p_idle) else $error("pins not idle after reset");
   property p_fall; $fell(select_n) |-> req_ready; endproperty
   a_fall: assert property (p_fall) else $error("select fell without a request");
   property p_acc; $fell(select_n) |-> !select_n[*8] ##1 !select_n[*8] ##1 select_n; endproperty
   a_acc: assert property (p_acc) else $error("select low time wrong");
   property p_pre; $rose(select_n) |-> select_n[*8] ##1 select_n[*5]; endproperty
   a_pre: assert property (p_pre) else $error("precharge too short");
   property p_rstpre; $rose(rst_n) |-> select_n[*8] ##1 select_n[*5]; endproperty
   a_rstpre: assert property (p_rstpre) else $error("precharge cut after reset");
   property p_addr; !select_n && !$past(select_n) |-> $stable(mem_addr_lines); endproperty
   a_addr: assert property (p_addr) else $error("address moved in cycle");
   property p_wr; !write_strobe_n |-> !select_n && !byte_lanes_oe_n; endproperty
   a_wr: assert property (p_wr) else $error("strobe outside select");
   property p_wd; !byte_lanes_oe_n && !$past(byte_lanes_oe_n) |-> $stable(byte_lanes_o); endproperty
   a_wd: assert property (p_wd) else $error("write data moved");
   property p_rsp; req_ready |-> ##28 rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("response late or early");
   // Main scenarios.
   c_rd: cover property ($fell(select_n) && write_strobe_n && !output_drive_n);
   c_wr: cover property ($fell(select_n) && !write_strobe_n);
   c_b2b: cover property (rsp_valid ##2 req_ready);
endmodule : bnp_host_ctrl_properties

// ==== bnp_mem_model.sv ====
module bnp_mem_model
   import bnp_pkg::*;
(
   input wire logic [ADDR_W-1:0] mem_addr_lines, // Address pins.
   input wire logic select_n, // Chip select.
   input wire logic write_strobe_n, // Write strobe.
   input wire logic output_drive_n, // Output enable.
   input wire logic [DATA_W-1:0] byte_lanes_i, // Wire level.
   output logic [DATA_W-1:0] dev_q, // Read data.
   output logic dev_drv // High while the device drives.
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // Behavioural byte array.
   // ********
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] lat_a = '0;
   logic [DATA_W-1:0] lanes_d;
   logic wr_cyc = 1'h0;
   logic ok = 1'h0;
   // Select fall starts a cycle; data is valid 1 ns before the access time.
   // Address and mode are taken 1 ns after the fall, as a hold time, because
   // the host launches them on the same clock edge as select.
   always @(negedge select_n) begin
      ok = 1'h0;
      ok <= #(ACCESS_TIME_NS - 1) 1'h1;
      #1;
      lat_a = mem_addr_lines;
      wr_cyc = !write_strobe_n;
   end
   // Delayed copy of the wire: the array takes data that stood before the end.
   always @(byte_lanes_i) lanes_d <= #1 byte_lanes_i;
   // The first rising strobe ends the write.
   always @(posedge write_strobe_n or posedge select_n) begin
      if (wr_cyc) mem[lat_a] = lanes_d;
      wr_cyc = 1'h0;
      if (select_n) ok = 1'h0;
   end
   // Drive only valid data, never in a write, and float while disabled.
   assign dev_drv = ok && !select_n && !output_drive_n && !wr_cyc;
   assign dev_q = mem[lat_a];
endmodule : bnp_mem_model

// ==== bnp_pkg.sv ====
package bnp_pkg;

   // ****************************************************************
   // Array geometry.
   // ****************************************************************
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;

   // ****************************************************************
   // Bus timing in nanoseconds and derived cycle counts at 200 MHz.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int ACCESS_TIME_NS = 70;
   localparam int CYCLE_TIME_NS = 130;
   localparam int PRECHARGE_MIN_TIME_NS = 60;
   localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_CYC = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHARGE_CYC = (PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 6;

   // ****************************************************************
   // Reset values of the memory pins.
   // ****************************************************************
   localparam logic PIN_IDLE = 1'h1;

   // ****************************************************************
   // Controller states.
   // ****************************************************************
   typedef enum logic [3:0] {
      BNP_IDLE = 4'h1,
      BNP_ACCESS = 4'h2,
      BNP_PRECHARGE = 4'h4,
      BNP_DONE = 4'h8
   } bnp_state_t;

endpackage : bnp_pkg

// ==== tb_bytewide_nvram_parallel_port.sv ====
module tb_bytewide_nvram_parallel_port
   import bnp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // Stimulus, wire and reference.
   // ********
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic req_valid = 1'h0;
   logic req_write = 1'h0;
   logic [ADDR_W-1:0] req_addr = 15'h0000;
   logic [DATA_W-1:0] req_wdata = 8'h00;
   logic req_ready, rsp_valid, select_n, write_strobe_n, output_drive_n, oe_n, dev_drv;
   logic [DATA_W-1:0] rsp_rdata, lanes_o, dev_q, lanes_w;
   logic [DATA_W-1:0] last_w = 8'h00;
   logic [ADDR_W-1:0] mem_addr_lines;
   logic [31:0] seed = 32'h8d9e2453;
   logic [DATA_W-1:0] ref_mem [int];
   logic [ADDR_W-1:0] addr_q [$];
   int fail_count = 0;
   int num_checks = 0;
   // Clock of 5 ns.
   initial forever #2.5 sys_clk = ~sys_clk;
   // Released lanes show the inverse of the last driven value.
   assign lanes_w = !oe_n ? lanes_o : dev_drv ? dev_q : ~last_w;
   always @(posedge sys_clk) begin
      if (!oe_n || dev_drv) last_w <= lanes_w;
      if (!oe_n && dev_drv === 1'h1) chk(1, 0);
   end
   bnp_host_ctrl dut (.sys_clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata,
      .req_ready, .rsp_valid, .rsp_rdata, .mem_addr_lines, .select_n, .write_strobe_n,
      .output_drive_n, .byte_lanes_i(lanes_w), .byte_lanes_o(lanes_o), .byte_lanes_oe_n(oe_n));
   bnp_mem_model u_mem (.mem_addr_lines, .select_n, .write_strobe_n, .output_drive_n,
      .byte_lanes_i(lanes_w), .dev_q, .dev_drv);
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task report_and_stop();
      if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // One access; the request stays up until taken, the address then moves.
   task access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      {req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
      do begin
         @(posedge sys_clk) #1;
         n++;
      end while (req_ready !== 1'h1 && n < 40);
      chk(req_ready, 1'h1);
      if (req_ready !== 1'h1) report_and_stop();
      req_valid = 1'h0;
      req_addr = ADDR_W'(rnd());
      n = 0;
      do begin
         @(posedge sys_clk) #1;
         n++;
      end while (rsp_valid !== 1'h1 && n < 40);
      chk(n, 28);
      if (n >= 40) report_and_stop();
      if (w) ref_mem[a] = d;
      else chk(rsp_rdata, ref_mem[a]);
   endtask : access
   // Main sequence.
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 rst_n = 1'h1;
      chk({select_n, write_strobe_n, output_drive_n, oe_n}, 4'hf);
      addr_q = '{15'h0000, 15'h7fff};
      access(1'h1, 15'h0000, 8'h5a);
      access(1'h1, 15'h7fff, 8'ha5);
      repeat (6) begin
         addr_q.push_back(ADDR_W'(rnd()));
         access(1'h1, addr_q[$], DATA_W'(rnd()));
      end
      foreach (addr_q[i]) access(1'h0, addr_q[i], 8'h00);
      access(1'h1, 15'h0000, 8'hc3);
      access(1'h0, 15'h0000, 8'h00);
      req_valid = 1'h1;
      repeat (6) @(posedge sys_clk) #1;
      rst_n = 1'h0;
      req_valid = 1'h0;
      repeat (2) @(posedge sys_clk) #1;
      chk({select_n, write_strobe_n, output_drive_n, oe_n}, 4'hf);
      rst_n = 1'h1;
      access(1'h0, 15'h7fff, 8'h00);
      report_and_stop();
   end
endmodule : tb_bytewide_nvram_parallel_port
bind bnp_host_ctrl bnp_host_ctrl_properties u_props (.sys_clk, .rst_n, .req_ready, .rsp_valid,
   .mem_addr_lines, .select_n, .write_strobe_n, .output_drive_n, .byte_lanes_o,
   .byte_lanes_oe_n);
